/* File: logic/ipam_defs.svh */
/*
 * Offsets, limits, reset values and timing counts of the input
 * polarity and analog curve mapping block.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef IPAM_DEFS_SVH
`define IPAM_DEFS_SVH

// ************************************************************
// Register word offsets
// ************************************************************
`define IPAM_OFS_POL_A        8'h00
`define IPAM_OFS_POL_B        8'h01
`define IPAM_OFS_CURVE_SEL    8'h02
`define IPAM_OFS_BELOW_MIN    8'h03
`define IPAM_OFS_CUR_MODE     8'h04
`define IPAM_OFS_SW_STATUS    8'h05
`define IPAM_OFS_FILT_BASE    8'h08
`define IPAM_OFS_JPT_BASE     8'h0c
`define IPAM_OFS_JAMP_BASE    8'h10
`define IPAM_OFS_SETV_BASE    8'h14
`define IPAM_OFS_CURVE_BASE   8'h20
`define IPAM_OFS_CURVE_LAST   8'h47

// ************************************************************
// Reset values
// ************************************************************
`define IPAM_RST_CURVE_SEL    12'h321
`define IPAM_RST_FILT         10'h00a
`define IPAM_RST_JAMP         11'h005
`define IPAM_RST_X_MIN        11'h000
`define IPAM_RST_X_INF1       11'h12c
`define IPAM_RST_X_INF2       11'h258
`define IPAM_RST_X_MAX        11'h3e8
`define IPAM_RST_Y_MIN        12'h000
`define IPAM_RST_Y_INF1       12'h12c
`define IPAM_RST_Y_INF2       12'h258
`define IPAM_RST_Y_MAX        12'h3e8

// ************************************************************
// Limits and timing
// ************************************************************
`define IPAM_FILT_MAX         10'h3e8
`define IPAM_CURVE_CNT        3'h5
`define IPAM_CLK_PERIOD_NS    100
`define IPAM_FILT_TICK_US     10000
`define IPAM_FRAC_BITS        8

`endif

/* File: logic/ipam_pkg.sv */
/*
 * Types of the input polarity and analog curve mapping block.
 * Assumes ipam_defs.svh holds all numeric constants.
 */
package ipam_pkg;

	typedef logic signed [11:0] ipam_pct_t;
	typedef logic        [10:0] ipam_volt_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [19:0] wdata;
		logic        wr;
		logic        rd;
	} ipam_bus_req_t;

	typedef struct packed {
		ipam_pct_t one;
		ipam_pct_t two;
		ipam_pct_t three;
	} ipam_setv_t;

endpackage : ipam_pkg

/* File: logic/ipam_top.sv */
/*
 * Input polarity and analog curve mapping block: polarity for seven
 * switched inputs, filtering, curve mapping and jump holding for three
 * analog inputs, and a plain register port.
 * Assumes switch and converter inputs are synchronous to clk_sys_i and
 * analog readings arrive in units of 0.01 V (or 0.01 mA in current mode).
 */
// Chosen here: the address-and-strobe port and the placing of the registers.
// Contract
// - Polarity of switch one is units digit of setting A; 0 is positive.
// - Switches two to five use tens..ten-thousands digits of A, each 0 or 1.
// - Switches six and seven use units and tens of setting B; default positive.
// - Positive polarity is active when closed; inverse polarity reverses this.
// - Analog readings map linearly to -100.0..100.0 percent; default 0V..10V.
// - Readings above curve maximum are computed as the maximum input.
// - In current mode one milliampere counts as half a volt.
// - Each analog input has its own filter time 0..10 s, default 0.10 s.
// - Curve choice per input from selection digits 1..5, default 321.
// - Curves one to three are two-point; four and five are four-point.
// - Four-point defaults 3V at 30 percent and 6V at 60 percent.
// - Below minimum gives curve minimum setting on digit 0, zero on 1.
// - Values within jump amplitude of the jump point become the point.
`timescale 1ns/100ps
`include "ipam_defs.svh"

module ipam_top
	import ipam_pkg::*;
#(
	parameter int FILT_TICK_CYCLES =
		`IPAM_FILT_TICK_US * 1000 / `IPAM_CLK_PERIOD_NS
)
(
	input  wire logic          clk_sys_i,
	input  wire logic          rst_i,
	input  wire ipam_bus_req_t bus_i,
	output logic [15:0]        rdata_o,
	input  wire logic [6:0]    switch_input_i,
	input  wire logic [11:0]   analog_in_one_i,
	input  wire logic [11:0]   analog_in_two_i,
	input  wire logic [11:0]   analog_in_three_i,
	output logic [6:0]         switch_active_o,
	output ipam_setv_t         setv_o
);

	localparam int TW = $clog2(FILT_TICK_CYCLES + 1);
	localparam int FB = `IPAM_FRAC_BITS;

	generate
		if (FILT_TICK_CYCLES < 1)
		begin : g_bad
			$error("FILT_TICK_CYCLES must be at least one");
		end
	endgenerate

	// ************************************************************
	// Functions
	// ************************************************************
	// Keep a stored digit when the written digit is out of its range.
	function automatic logic [2:0] digit_upd(input logic [2:0] old,
		input logic [3:0] nib, input logic [3:0] lo, input logic [3:0] hi);
		if (nib >= lo && nib <= hi)
			digit_upd = nib[2:0];
		else
			digit_upd = old;
	endfunction : digit_upd

	function automatic ipam_pct_t lerp(input int v, input int xa,
		input int xb, input int ya, input int yb);
		int r;
		r = ya;
		if (xb > xa)
			r = ya + ((v - xa) * (yb - ya)) / (xb - xa);
		lerp = ipam_pct_t'(r);
	endfunction : lerp

	function automatic int iabs(input int a);
		iabs = (a < 0) ? -a : a;
	endfunction : iabs

	// ************************************************************
	// Configuration registers
	// ************************************************************
	logic [6:0]      pol_q;
	logic [2:0]      csel_q [3];
	logic [2:0]      bmin_q;
	logic [2:0]      cmode_q;
	logic [9:0]      filt_q [3];
	ipam_pct_t       jpt_q  [3];
	logic [10:0]     jamp_q [3];
	ipam_volt_t      cx_q   [5][4];
	ipam_pct_t       cy_q   [5][4];

	wire logic [7:0] cidx    = bus_i.addr - `IPAM_OFS_CURVE_BASE;
	wire logic       c_hit   = bus_i.addr >= `IPAM_OFS_CURVE_BASE &&
		bus_i.addr <= `IPAM_OFS_CURVE_LAST;
	wire logic [2:0] c_crv   = cidx[5:3];
	wire logic [1:0] c_pt    = cidx[2:1];
	wire logic [1:0] a_sub   = bus_i.addr[1:0];
	wire logic [5:0] a_grp   = bus_i.addr[7:2];
	wire logic       a_trip  = a_sub != 2'h3;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			pol_q   <= 7'h00;
			bmin_q  <= 3'h0;
			cmode_q <= 3'h0;
			for (int i = 0; i < 3; i++)
			begin
				csel_q[i] <= 3'(`IPAM_RST_CURVE_SEL >> (4 * i));
				filt_q[i] <= `IPAM_RST_FILT;
				jpt_q[i]  <= 12'sh000;
				jamp_q[i] <= `IPAM_RST_JAMP;
			end
			for (int c = 0; c < 5; c++)
			begin
				cx_q[c][0] <= `IPAM_RST_X_MIN;
				cx_q[c][1] <= `IPAM_RST_X_INF1;
				cx_q[c][2] <= `IPAM_RST_X_INF2;
				cx_q[c][3] <= `IPAM_RST_X_MAX;
				cy_q[c][0] <= `IPAM_RST_Y_MIN;
				cy_q[c][1] <= `IPAM_RST_Y_INF1;
				cy_q[c][2] <= `IPAM_RST_Y_INF2;
				cy_q[c][3] <= `IPAM_RST_Y_MAX;
			end
		end
		else if (bus_i.wr)
		begin
			case (bus_i.addr)
				`IPAM_OFS_POL_A:
					// digits limited to 0 or 1
					for (int k = 0; k < 5; k++)
						pol_q[k] <= digit_upd({2'h0, pol_q[k]},
							bus_i.wdata[4*k +: 4], 4'h0, 4'h1)
							== 3'h1;
				`IPAM_OFS_POL_B:
					for (int k = 0; k < 2; k++)
						pol_q[5+k] <= digit_upd({2'h0, pol_q[5+k]},
							bus_i.wdata[4*k +: 4], 4'h0, 4'h1)
							== 3'h1;
				`IPAM_OFS_CURVE_SEL:
					for (int i = 0; i < 3; i++)
						csel_q[i] <= digit_upd(csel_q[i],
							bus_i.wdata[4*i +: 4], 4'h1, 4'h5);
				`IPAM_OFS_BELOW_MIN:
					for (int i = 0; i < 3; i++)
						bmin_q[i] <= digit_upd({2'h0, bmin_q[i]},
							bus_i.wdata[4*i +: 4], 4'h0, 4'h1)
							== 3'h1;
				`IPAM_OFS_CUR_MODE:
					cmode_q <= bus_i.wdata[2:0];
				default:
				begin
					if (a_grp == (`IPAM_OFS_FILT_BASE >> 2) && a_trip &&
						bus_i.wdata[9:0] <= `IPAM_FILT_MAX)
						filt_q[a_sub] <= bus_i.wdata[9:0];
					if (a_grp == (`IPAM_OFS_JPT_BASE >> 2) && a_trip)
						jpt_q[a_sub] <= bus_i.wdata[11:0];
					if (a_grp == (`IPAM_OFS_JAMP_BASE >> 2) && a_trip)
						jamp_q[a_sub] <= bus_i.wdata[10:0];
					if (c_hit && c_crv < `IPAM_CURVE_CNT)
					begin
						if (cidx[0])
							cy_q[c_crv][c_pt] <= bus_i.wdata[11:0];
						else
							cx_q[c_crv][c_pt] <= bus_i.wdata[10:0];
					end
				end
			endcase
		end
	end

	// ************************************************************
	// Switched inputs
	// ************************************************************
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			switch_active_o <= 7'h00;
		else
			switch_active_o <= switch_input_i ^ pol_q;
	end

	// ************************************************************
	// Filter tick
	// ************************************************************
	logic [TW-1:0] tick_q;
	wire logic     tick = tick_q == TW'(FILT_TICK_CYCLES - 1);

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || tick)
			tick_q <= '0;
		else
			tick_q <= tick_q + 1'b1;
	end

	// ************************************************************
	// Analog path
	// ************************************************************
	wire logic [11:0] raw [3] = '{analog_in_one_i, analog_in_two_i,
		analog_in_three_i};
	ipam_pct_t        res [3];

	generate
		for (genvar g = 0; g < 3; g++)
		begin : g_ain
			logic [11+FB:0]  flt_q;
			logic [11:0]     volt;
			logic [11+FB:0]  flt_d;
			int              vin;
			int              x0;
			int              x1;
			int              x2;
			int              x3;
			int              y0;
			ipam_pct_t       mapped;
			int              diff;
			logic [2:0]      cv;
			logic            four;

			assign volt = cmode_q[g] ? {1'b0, raw[g][11:1]} : raw[g];

			always_comb
			begin
				flt_d = flt_q;
				if (filt_q[g] == 10'h000)
					flt_d = {volt, {FB{1'b0}}};
				else if (tick)
					flt_d = (12+FB)'(int'(flt_q) +
						(int'({volt, {FB{1'b0}}}) - int'(flt_q)) /
						(int'(filt_q[g]) + 1));
			end

			always_ff @(posedge clk_sys_i)
			begin
				if (rst_i)
					flt_q <= '0;
				else
					flt_q <= flt_d;
			end

			assign cv   = csel_q[g] - 3'h1;
			// curves four and five use all points
			assign four = cv >= 3'h3;
			assign vin  = int'(flt_q[11+FB:FB]);
			assign x0   = int'(cx_q[cv][0]);
			assign x1   = int'(cx_q[cv][1]);
			assign x2   = int'(cx_q[cv][2]);
			assign x3   = int'(cx_q[cv][3]);
			assign y0   = int'(cy_q[cv][0]);

			assign mapped =
				(vin >= x3) ? cy_q[cv][3] :
				(vin < x0) ? (bmin_q[g] ? 12'sh000 : cy_q[cv][0]) :
				!four ? lerp(vin, x0, x3, y0, int'(cy_q[cv][3])) :
				(vin < x1) ? lerp(vin, x0, x1, y0, int'(cy_q[cv][1])) :
				(vin < x2) ? lerp(vin, x1, x2, int'(cy_q[cv][1]),
					int'(cy_q[cv][2])) :
				lerp(vin, x2, x3, int'(cy_q[cv][2]), int'(cy_q[cv][3]));

			assign diff   = int'(mapped) - int'(jpt_q[g]);
			assign res[g] = (iabs(diff) <= int'(jamp_q[g])) ? jpt_q[g]
				: mapped;
		end
	endgenerate

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			setv_o <= '0;
		else
			setv_o <= '{res[0], res[1], res[2]};
	end

	// ************************************************************
	// Read port
	// ************************************************************
	// Digits read back in nibble form, except polarity A: five nibbles do
	// not fit the 16-bit read port, so it returns one bit per switch.
	wire logic [15:0] rd_mux =
		(bus_i.addr == `IPAM_OFS_POL_A) ?
			{11'h000, pol_q[4:0]} :
		(bus_i.addr == `IPAM_OFS_POL_B) ?
			{11'h000, pol_q[6], 3'h0, pol_q[5]} :
		(bus_i.addr == `IPAM_OFS_CURVE_SEL) ?
			{5'h00, csel_q[2], 1'b0, csel_q[1], 1'b0, csel_q[0]} :
		(bus_i.addr == `IPAM_OFS_BELOW_MIN) ?
			{7'h00, bmin_q[2], 3'h0, bmin_q[1], 3'h0, bmin_q[0]} :
		(bus_i.addr == `IPAM_OFS_CUR_MODE) ? {13'h0000, cmode_q} :
		(bus_i.addr == `IPAM_OFS_SW_STATUS) ? {9'h000, switch_active_o} :
		(a_grp == (`IPAM_OFS_FILT_BASE >> 2) && a_trip) ?
			{6'h00, filt_q[a_sub]} :
		(a_grp == (`IPAM_OFS_JPT_BASE >> 2) && a_trip) ?
			{{4{jpt_q[a_sub][11]}}, jpt_q[a_sub]} :
		(a_grp == (`IPAM_OFS_JAMP_BASE >> 2) && a_trip) ?
			{5'h00, jamp_q[a_sub]} :
		(bus_i.addr == `IPAM_OFS_SETV_BASE) ?
			{{4{setv_o.one[11]}}, setv_o.one} :
		(bus_i.addr == `IPAM_OFS_SETV_BASE + 8'h01) ?
			{{4{setv_o.two[11]}}, setv_o.two} :
		(bus_i.addr == `IPAM_OFS_SETV_BASE + 8'h02) ?
			{{4{setv_o.three[11]}}, setv_o.three} :
		(c_hit && c_crv < `IPAM_CURVE_CNT) ?
			(cidx[0] ? {{4{cy_q[c_crv][c_pt][11]}}, cy_q[c_crv][c_pt]}
			: {5'h00, cx_q[c_crv][c_pt]}) :
		16'h0000;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			rdata_o <= 16'h0000;
		else if (bus_i.rd)
			rdata_o <= rd_mux;
		else
			rdata_o <= 16'h0000;
	end

endmodule : ipam_top

/* File: testbench/ipam_chk_properties.sv */
/*
 * Port checker of the polarity and curve mapping block.
 * Assumes it is bound to ipam_top and sees its ports only.
 */
`timescale 1ns/100ps
module ipam_chk
	import ipam_pkg::*;
(
	input  wire logic          clk_sys_i,
	input  wire logic          rst_i,
	input  wire ipam_bus_req_t bus_i,
	input  wire logic [15:0]   rdata_o,
	input  wire logic [6:0]    switch_input_i,
	input  wire logic [6:0]    switch_active_o,
	input  wire ipam_setv_t    setv_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// ************************************************************
	// Sequences and assertions
	// ************************************************************
	// Only digits that are 0 or 1 are accepted, so others are excluded.
	sequence pol_wr(a);
		bus_i.wr && bus_i.addr == a && bus_i.wdata[3:0] <= 4'h1 &&
		bus_i.wdata[7:4] <= 4'h1 && bus_i.wdata[11:8] <= 4'h1 &&
		bus_i.wdata[15:12] <= 4'h1 && bus_i.wdata[19:16] <= 4'h1;
	endsequence
	rst_clear_a: assert property (disable iff (1'b0) rst_i |=>
		setv_o == '0 && switch_active_o == 7'h00 && rdata_o == 16'h0000)
		else $error("outputs not cleared by reset");
	rd_idle_a: assert property (!$past(bus_i.rd) |-> rdata_o == 16'h0000)
		else $error("read data outside read slot");
	unmapped_rd_a: assert property ($past(bus_i.rd) &&
		($past(bus_i.addr) inside {8'h06, 8'h07} || $past(bus_i.addr) > 8'h47)
		|-> rdata_o == 16'h0000) else $error("unmapped read not zero");
	sw_follow_a: assert property (!bus_i.wr ##1 1'b1 |=>
		(switch_active_o ^ $past(switch_active_o)) ==
		($past(switch_input_i) ^ $past(switch_input_i, 2)))
		else $error("switch output not following input");
	pol_low_a: assert property (pol_wr(8'h00) |-> ##2
		switch_active_o[4:0] == ($past(switch_input_i[4:0]) ^
		{$past(bus_i.wdata[16], 2), $past(bus_i.wdata[12], 2),
		$past(bus_i.wdata[8], 2), $past(bus_i.wdata[4], 2),
		$past(bus_i.wdata[0], 2)}))
		else $error("polarity A digits not applied");
	pol_high_a: assert property (pol_wr(8'h01) ##1 !bus_i.wr |=>
		switch_active_o[6:5] == ($past(switch_input_i[6:5]) ^
		{$past(bus_i.wdata[4], 2), $past(bus_i.wdata[0], 2)}))
		else $error("polarity B digits not applied");
	range_one_a: assert property (setv_o.one >= -12'sd1000 &&
		setv_o.one <= 12'sd1000) else $error("set value one out of range");
	range_two_a: assert property (setv_o.two >= -12'sd1000 &&
		setv_o.two <= 12'sd1000) else $error("set value two out of range");
	range_three_a: assert property (setv_o.three >= -12'sd1000 &&
		setv_o.three <= 12'sd1000) else $error("set value three out of range");
endmodule : ipam_chk

bind ipam_top ipam_chk ipam_chk_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.bus_i(bus_i), .rdata_o(rdata_o), .switch_input_i(switch_input_i),
	.switch_active_o(switch_active_o), .setv_o(setv_o));

/* File: testbench/ipam_field.sv */
/*
 * Contacts and analog sources in front of the block, sampled once a cycle.
 * Assumes the bench sets the wanted levels on clk_sys_i.
 */
`timescale 1ns/100ps
module ipam_field (
	input  wire logic        clk_sys_i,
	input  wire logic [6:0]  contact_i,
	input  wire logic [11:0] lv1_i,
	input  wire logic [11:0] lv2_i,
	input  wire logic [11:0] lv3_i,
	output logic [6:0]       sw_o,
	output logic [11:0]      a1_o,
	output logic [11:0]      a2_o,
	output logic [11:0]      a3_o
);
	// The converter register adds one cycle before the block sees a level.
	always_ff @(posedge clk_sys_i)
	begin
		sw_o <= contact_i;
		a1_o <= lv1_i;
		a2_o <= lv2_i;
		a3_o <= lv3_i;
	end
endmodule : ipam_field

/* File: testbench/tb.sv */
/*
 * Self-checking bench of the polarity and curve mapping block.
 * Assumes ipam_defs.svh is on the include path.
 */
`timescale 1ns/100ps
module tb;
	import ipam_pkg::*;
	logic          clk_sys_i = 1'b0;
	logic          rst_i = 1'b1;
	ipam_bus_req_t bus = '0;
	logic [15:0]   rdata;
	logic [6:0]    contact = 7'h00, sw_raw, sw_act;
	logic [11:0]   lv1 = 12'h000, lv2 = 12'h000, lv3 = 12'h000;
	logic [11:0]   a1, a2, a3;
	ipam_setv_t    setv;
	logic [2:0]    snap = 3'h0;
	logic          rd_d = 1'b0;
	logic [18:0]   notes [$];
	int            failures = 0, compares = 0, seed = 11112, cyc = 0;
	logic [7:0]    ra [8] = '{8'h02, 8'h03, 8'h08, 8'h10, 8'h3a, 8'h3b,
		8'h06, 8'h50};
	logic [15:0]   re [8] = '{16'h0321, 16'h0000, 16'h000a, 16'h0005,
		16'h012c, 16'h012c, 16'h0000, 16'h0000};
	always #50 clk_sys_i = ~clk_sys_i;
	ipam_field ipam_field_i (.clk_sys_i(clk_sys_i), .contact_i(contact),
		.lv1_i(lv1), .lv2_i(lv2), .lv3_i(lv3), .sw_o(sw_raw), .a1_o(a1),
		.a2_o(a2), .a3_o(a3));
	// A short filter tick keeps the run brief.
	ipam_top #(.FILT_TICK_CYCLES(4)) ipam_top_i (.clk_sys_i(clk_sys_i),
		.rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
		.switch_input_i(sw_raw), .analog_in_one_i(a1),
		.analog_in_two_i(a2), .analog_in_three_i(a3),
		.switch_active_o(sw_act), .setv_o(setv));
	// ************************************************************
	// Tasks
	// ************************************************************
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task test_done;
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	// Strobes stay up between calls; idle drops them once.
	task wr(input logic [7:0] a, input logic [19:0] d);
		bus <= {a, d, 1'b1, 1'b0};
		@(posedge clk_sys_i);
	endtask : wr
	task rd(input logic [7:0] a, input logic [15:0] exp);
		notes.push_back({3'h0, exp});
		bus <= {a, 20'h00000, 1'b0, 1'b1};
		@(posedge clk_sys_i);
	endtask : rd
	task look(input logic [2:0] k, input logic [15:0] exp);
		notes.push_back({k, exp});
		snap <= k;
		@(posedge clk_sys_i);
	endtask : look
	task idle;
		bus <= '0;
		snap <= 3'h0;
		@(posedge clk_sys_i);
	endtask : idle
	// ************************************************************
	// Monitor
	// ************************************************************
	always @(posedge clk_sys_i)
	begin
		logic [18:0] n;
		logic [15:0] got;
		cyc++;
		if (cyc > 1000)
		begin
			failures++;
			test_done();
		end
		if (rd_d || snap != 3'h0)
		begin
			n = notes.pop_front();
			case (n[18:16])
				3'h1: got = {9'h000, sw_act};
				3'h2: got = {{4{setv.one[11]}}, setv.one};
				3'h3: got = {{4{setv.two[11]}}, setv.two};
				3'h4: got = {{4{setv.three[11]}}, setv.three};
				default: got = rdata;
			endcase
			cmp(got, n[15:0]);
		end
		rd_d = bus.rd;
	end
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++)
			rd(ra[i], re[i]);
		wr(8'h00, 20'h10101);
		wr(8'h01, 20'h00010);
		idle();
		for (int i = 0; i < 20; i++)
		begin
			contact <= 7'($random(seed));
			repeat (3) @(posedge clk_sys_i);
			look(3'h1, {9'h000, contact ^ 7'h55});
			idle();
		end
		wr(8'h08, 20'h00000);
		wr(8'h09, 20'h00000);
		wr(8'h0a, 20'h00000);
		// Curve four first inflection output moves to 10 percent, still above its minimum.
		wr(8'h3b, 20'h00064);
		wr(8'h02, 20'h00524);
		wr(8'h28, 20'h00064);
		wr(8'h29, 20'h000c8);
		wr(8'h04, 20'h00004);
		idle();
		lv1 <= 12'd450;
		lv2 <= 12'd50;
		lv3 <= 12'd800;
		repeat (6) @(posedge clk_sys_i);
		look(3'h2, 16'd350);
		look(3'h3, 16'd200);
		look(3'h4, 16'd400);
		idle();
		wr(8'h03, 20'h00010);
		idle();
		lv1 <= 12'd1200;
		lv3 <= 12'd8;
		repeat (6) @(posedge clk_sys_i);
		look(3'h2, 16'd1000);
		look(3'h3, 16'd0);
		look(3'h4, 16'd0);
		idle();
		test_done();
	end
endmodule : tb
